// ---- core/display_port_pkg.sv ----
package display_port_pkg;
  // Display memory and address decode.
  localparam int unsigned ADDR_W         = 23;
  localparam int unsigned MEM_ADDR_W     = 13;
  localparam int unsigned MEM_DATA_W     = 12;
  localparam int unsigned MODE_W         = 4;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned MODE_LSB       = 12;
  // Word address base of the 6K window, in 16-bit words.
  localparam logic [22:0] DISP_BASE      = 23'h00_6000;
  localparam logic [22:0] DISP_WORDS     = 23'h00_1800;
  localparam logic [3:0]  MODE_RESET     = 4'h0;
  // Acknowledge shift register.
  localparam int unsigned TAP_COUNT      = 4;
  localparam int unsigned WAIT_PER_TAP   = 2;
  localparam int unsigned SHIFT_LEN      = 7;
  // Access windows per tap, in ns, and the clock period in ns.
  localparam int unsigned CLOCK_NS       = 25;
  localparam int unsigned TAP0_ACCESS_NS = 250;
  localparam int unsigned TAP1_ACCESS_NS = 375;
  localparam int unsigned TAP2_ACCESS_NS = 500;
  localparam int unsigned TAP3_ACCESS_NS = 625;
  localparam int unsigned MEM_ACCESS_NS  = 300;
  // Chosen tap index for the fitted memory.
  localparam logic [1:0]  TAP_DEFAULT    = 2'h1;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISOLATE,
    ST_DESELECT,
    ST_CONNECT
  } sw_state_t;
endpackage

// ---- core/ack_shifter.sv ----
`timescale 1ns/1ps
`default_nettype none
// Wait-state shifter: a one loaded at the start of an access walks down
// the chain; every tap sits two positions beyond the previous one.
module ack_shifter (
  // Clock and reset.
  input  wire logic       clock,
  input  wire logic       rst,
  // Control.
  input  wire logic       start,
  input  wire logic       clear,
  input  wire logic [1:0] tap_sel,
  // Selected tap.
  output logic            tap_out
);
  logic [display_port_pkg::SHIFT_LEN-1:0] chain_reg;
  logic [display_port_pkg::TAP_COUNT-1:0] taps;

  // Shift chain, emptied when the strobes drop.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chain_reg <= '0;
    end else if (clear) begin
      chain_reg <= '0;
    end else begin
      chain_reg <= {chain_reg[display_port_pkg::SHIFT_LEN-2:0], start};
    end
  end

  // Taps every two stages apart.
  genvar g;
  generate
    for (g = 0; g < display_port_pkg::TAP_COUNT; g++) begin : g_tap
      assign taps[g] = chain_reg[g*display_port_pkg::WAIT_PER_TAP];
    end
  endgenerate

  assign tap_out = taps[tap_sel];
endmodule
`default_nettype wire

// ---- core/shared_display_memory_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module shared_display_memory_port #(
  parameter logic [1:0] ACK_TAP = display_port_pkg::TAP_DEFAULT
) (
  // Clock and reset.
  input  wire logic                                  clock,
  input  wire logic                                  rst,
  // Processor bus; addr is a word address, strobes are active low.
  input  wire logic [display_port_pkg::ADDR_W-1:0]   cpu_addr,
  input  wire logic                                  cpu_as_n,
  input  wire logic                                  cpu_uds_n,
  input  wire logic                                  cpu_lds_n,
  input  wire logic                                  cpu_read,
  input  wire logic [display_port_pkg::DATA_W-1:0]   cpu_wdata,
  output logic                                       transfer_acknowledge_n,
  // Display side controls.
  input  wire logic                                  frame_sync,
  output logic                                       gen_addr_oe_n,
  output logic                                       gen_decoder_sel,
  output logic                                       cpu_addr_buf_oe_n,
  output logic                                       cpu_data_buf_oe_n,
  output logic                                       cpu_data_dir_read,
  output logic                                       mem_write_n,
  output logic [display_port_pkg::MODE_W-1:0]        video_display_generator_mode
);
  // Cycles from the buffers switching on to the acknowledge edge: two for the
  // shifter entry and the acknowledge flop, then two more for every tap step.
  // The latency check below relies on this figure.
  localparam int unsigned ACK_LAT = 2 + display_port_pkg::WAIT_PER_TAP * ACK_TAP;

  // Decoded processor bus.
  logic                                  strobe_active;
  logic                                  access_hit;
  logic                                  even_word;
  logic                                  mode_load;
  logic [display_port_pkg::MODE_W-1:0]   mode_field;
  // Switch-over sequencer.
  display_port_pkg::sw_state_t           state_reg;
  display_port_pkg::sw_state_t           state_next;
  // Acknowledge path.
  logic                                  shift_start;
  logic                                  shift_clear;
  logic                                  tap_hit;
  logic                                  ack_next;
  // Cycles spent with the buffers connected, watched by the latency check.
  logic [3:0]                            conn_cnt_reg;
  logic [3:0]                            conn_cnt_next;

  // True when a word address falls inside the display window.
  function automatic logic in_display_window(
    input logic [display_port_pkg::ADDR_W-1:0] addr
  );
    logic above_base;
    logic below_top;
    above_base = (addr >= display_port_pkg::DISP_BASE);
    below_top  = (addr < (display_port_pkg::DISP_BASE + display_port_pkg::DISP_WORDS));
    return above_base && below_top;
  endfunction

  // True in the state where the processor buffers may drive the memory.
  function automatic logic is_connected(input display_port_pkg::sw_state_t s);
    return (s == display_port_pkg::ST_CONNECT);
  endfunction

  // True while the generator still drives its address bus.
  function automatic logic gen_address_on(input display_port_pkg::sw_state_t s);
    return (s == display_port_pkg::ST_IDLE);
  endfunction

  // True while the generator-side decoder still selects the memories.
  function automatic logic gen_decoder_on(input display_port_pkg::sw_state_t s);
    return (s == display_port_pkg::ST_IDLE) || (s == display_port_pkg::ST_ISOLATE);
  endfunction

  // Address strobe plus either data strobe marks a live access.
  assign strobe_active = !cpu_as_n && (!cpu_uds_n || !cpu_lds_n);
  // Only accesses that land in the window take the memory away.
  assign access_hit    = strobe_active && in_display_window(cpu_addr);
  // The word address bit zero tells even from odd locations.
  assign even_word     = !cpu_addr[0];
  // Mode bits travel in the top nibble of the data word.
  assign mode_field    = cpu_wdata[display_port_pkg::MODE_LSB +: display_port_pkg::MODE_W];
  // The latch takes only writes to even words once the buffers are connected.
  assign mode_load     = is_connected(state_reg) && access_hit && !cpu_read
                         && even_word && !cpu_uds_n;

  // Next-state logic: step through the switch-over states while the access
  // stands; losing the strobes at any point returns straight to idle, so an
  // aborted access never leaves the generator cut off.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      display_port_pkg::ST_IDLE: begin
        if (access_hit) begin
          state_next = display_port_pkg::ST_ISOLATE;
        end
      end
      display_port_pkg::ST_ISOLATE: begin
        if (access_hit) begin
          state_next = display_port_pkg::ST_DESELECT;
        end else begin
          state_next = display_port_pkg::ST_IDLE;
        end
      end
      display_port_pkg::ST_DESELECT: begin
        if (access_hit) begin
          state_next = display_port_pkg::ST_CONNECT;
        end else begin
          state_next = display_port_pkg::ST_IDLE;
        end
      end
      display_port_pkg::ST_CONNECT: begin
        if (!access_hit) begin
          state_next = display_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = display_port_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= display_port_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Switch pins follow the next state so each step shows one cycle after
  // the last; the release at the end of an access happens in one cycle.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gen_addr_oe_n     <= 1'b0;
      gen_decoder_sel   <= 1'b1;
      cpu_addr_buf_oe_n <= 1'b1;
      cpu_data_buf_oe_n <= 1'b1;
    end else begin
      gen_addr_oe_n     <= !gen_address_on(state_next);
      gen_decoder_sel   <= gen_decoder_on(state_next);
      cpu_addr_buf_oe_n <= !is_connected(state_next);
      cpu_data_buf_oe_n <= !is_connected(state_next);
    end
  end

  // Transceiver direction and memory write strobe, active only when connected.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_data_dir_read <= 1'b0;
      mem_write_n       <= 1'b1;
    end else begin
      cpu_data_dir_read <= is_connected(state_next) && cpu_read;
      mem_write_n       <= !(is_connected(state_next) && !cpu_read);
    end
  end

  // Mode latch: four bits beside the twelve-bit memory, held between writes;
  // an even write loads it at once, whatever the level of frame_sync.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      video_display_generator_mode <= display_port_pkg::MODE_RESET;
    end else if (mode_load) begin
      video_display_generator_mode <= mode_field;
    end
  end

  // The shifter runs only while connected and empties when the strobes drop.
  assign shift_start = is_connected(state_reg) && access_hit;
  assign shift_clear = !access_hit;
  // Acknowledge only from the chosen tap and only while the access stands.
  assign ack_next    = tap_hit && shift_start;

  // Wait-state shifter with a fixed tap.
  ack_shifter i_ack_shifter (
    .clock   (clock),
    .rst     (rst),
    .start   (shift_start),
    .clear   (shift_clear),
    .tap_sel (ACK_TAP),
    .tap_out (tap_hit)
  );

  // Acknowledge flop; it drops back one cycle after the strobes go away.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      transfer_acknowledge_n <= 1'b1;
    end else begin
      transfer_acknowledge_n <= !ack_next;
    end
  end

  // Connected-cycle count, saturating so a stalled access cannot wrap it.
  always_comb begin
    if (!is_connected(state_reg)) begin
      conn_cnt_next = 4'h0;
    end else if (conn_cnt_reg == 4'hf) begin
      conn_cnt_next = conn_cnt_reg;
    end else begin
      conn_cnt_next = conn_cnt_reg + 4'h1;
    end
  end

  // Connected-cycle counter state.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      conn_cnt_reg <= 4'h0;
    end else begin
      conn_cnt_reg <= conn_cnt_next;
    end
  end

  // The generator decoder drops only once its address bus already floats.
  property p_decoder_after_hiz;
    @(posedge clock) disable iff (rst)
      $fell(gen_decoder_sel) |-> $past(gen_addr_oe_n);
  endproperty
  a_decoder_after_hiz: assert property (p_decoder_after_hiz)
    else $error("generator decoder dropped before its address bus floated");

  // The processor buffers open only after both generator steps are done.
  property p_buffers_after_deselect;
    @(posedge clock) disable iff (rst)
      $fell(cpu_addr_buf_oe_n) |-> ($past(gen_addr_oe_n) && !$past(gen_decoder_sel));
  endproperty
  a_buffers_after_deselect: assert property (p_buffers_after_deselect)
    else $error("processor buffers opened before the generator let go");

  // While the buffers drive, the generator address stays floating.
  property p_gen_hiz_while_connected;
    @(posedge clock) disable iff (rst)
      !cpu_addr_buf_oe_n |-> (gen_addr_oe_n && !gen_decoder_sel);
  endproperty
  a_gen_hiz_while_connected: assert property (p_gen_hiz_while_connected)
    else $error("generator address driven during a processor access");

  // Buffers are open only when an access stood at the previous edge.
  property p_buffers_need_access;
    @(posedge clock) disable iff (rst)
      !cpu_data_buf_oe_n |-> $past(access_hit);
  endproperty
  a_buffers_need_access: assert property (p_buffers_need_access)
    else $error("processor buffers open with no display access");

  // With no access at the previous edge everything is handed back.
  property p_released_when_idle;
    @(posedge clock) disable iff (rst)
      !$past(access_hit) |-> (!gen_addr_oe_n && gen_decoder_sel
                              && cpu_addr_buf_oe_n && cpu_data_buf_oe_n);
  endproperty
  a_released_when_idle: assert property (p_released_when_idle)
    else $error("memory not handed back to the generator when idle");

  // Acknowledge appears only with the buffers connected.
  property p_ack_only_connected;
    @(posedge clock) disable iff (rst)
      !transfer_acknowledge_n |-> !cpu_data_buf_oe_n;
  endproperty
  a_ack_only_connected: assert property (p_ack_only_connected)
    else $error("acknowledge given without connected buffers");

  // Acknowledge is withdrawn the cycle after the strobes go away.
  property p_ack_withdrawn;
    @(posedge clock) disable iff (rst)
      !access_hit |=> transfer_acknowledge_n;
  endproperty
  a_ack_withdrawn: assert property (p_ack_withdrawn)
    else $error("acknowledge held after the strobes were negated");

  // Acknowledge arrives the chosen number of cycles after connection.
  property p_ack_latency;
    @(posedge clock) disable iff (rst)
      $fell(transfer_acknowledge_n) |-> (conn_cnt_reg == 4'(ACK_LAT));
  endproperty
  a_ack_latency: assert property (p_ack_latency)
    else $error("acknowledge arrived with the wrong number of wait states");

  // The mode outputs change only after a latch load.
  property p_mode_holds;
    @(posedge clock) disable iff (rst)
      $changed(video_display_generator_mode) |-> $past(mode_load);
  endproperty
  a_mode_holds: assert property (p_mode_holds)
    else $error("mode outputs changed without an even write");

  // Scenario coverage: an even write during blanking, a read through the
  // buffers, an access outside the window and an access given up early.
  c_mode_load_in_blank: cover property (@(posedge clock) disable iff (rst)
    mode_load && !frame_sync);
  c_read_connected: cover property (@(posedge clock) disable iff (rst)
    cpu_data_dir_read && !transfer_acknowledge_n);
  c_outside_window: cover property (@(posedge clock) disable iff (rst)
    strobe_active && !access_hit);
  c_aborted_switch: cover property (@(posedge clock) disable iff (rst)
    (state_reg == display_port_pkg::ST_ISOLATE) && !access_hit);
endmodule
`default_nettype wire

// ---- tb/cpu_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_master (
  input  wire logic        clock,
  input  wire logic        ack_n,
  output var  logic [22:0] addr = '1,
  output var  logic        strobe_n = 1'b1,
  output var  logic [15:0] wdata = '1);
  // Access held until acknowledge is seen low or 40 polls pass; the released bus shows inverted values.
  task automatic cycle(input logic [22:0] a, input logic [15:0] d, output int w);
    @(posedge clock);
    {addr, wdata, strobe_n} <= {a, d, 1'b0};
    for (w = 0; w == 0 || (ack_n !== 1'b0 && w < 40); w++) @(posedge clock);
    {addr, wdata, strobe_n} <= {~a, ~d, 1'b1};
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_shared_display_memory_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_shared_display_memory_port;
  // Tap fitted for the 300 ns memories.
  localparam int unsigned TAP_USED  = 1;
  // Polls from strobe to acknowledge: strobe sampling, three switch steps, the
  // shifter entry and the acknowledge flop, then two more per tap step.
  localparam int unsigned POLL_BASE = 6;
  logic        clock = 1'b0, rst = 1'b1, fs = 1'b0, rd = 1'b0, ack_n, stb_n; // Frame sync low.
  logic        dir_rd, wr_n, seen_rd, seen_wr;
  logic [3:0]  mode, sw;
  logic [22:0] ad;
  logic [15:0] wd;
  int          bad_count, n_checks, w, cyc, mon_cyc, t_iso, t_desel, t_conn;
  shared_display_memory_port i_shared_display_memory_port (.clock, .rst, .cpu_addr(ad),
    .cpu_as_n(stb_n), .cpu_uds_n(stb_n), .cpu_lds_n(stb_n), .cpu_read(rd), .frame_sync(fs),
    .cpu_wdata(wd), .transfer_acknowledge_n(ack_n), .gen_addr_oe_n(sw[3]),
    .gen_decoder_sel(sw[2]), .cpu_addr_buf_oe_n(sw[1]), .cpu_data_buf_oe_n(sw[0]),
    .cpu_data_dir_read(dir_rd), .mem_write_n(wr_n), .video_display_generator_mode(mode));
  cpu_master i_cpu_master (.clock, .ack_n, .addr(ad), .strobe_n(stb_n), .wdata(wd));
  // Access monitor: edge at which each switch step is first seen, and whether
  // the direction and write strobe were ever active.
  always @(posedge clock) begin
    mon_cyc++;
    if (sw[3] && t_iso == 0) t_iso = mon_cyc;
    if (!sw[2] && t_desel == 0) t_desel = mon_cyc;
    if (sw[1:0] == 2'b00 && t_conn == 0) t_conn = mon_cyc;
    seen_rd = seen_rd | dir_rd;
    seen_wr = seen_wr | !wr_n;
  end
  task automatic check(input string what, input logic [15:0] seen, exp);
    {n_checks, bad_count} = {n_checks + 1, bad_count + int'(seen !== exp)};
    if (seen !== exp) $display("unexpected %s expected %h seen %h", what, exp, seen);
  endtask
  task automatic end_of_test(input int extra);
    bad_count += extra;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One processor access; hit says whether it falls in the window, and a miss
  // runs the master's 40-poll limit with no acknowledge.
  task automatic access(input logic r, input logic [22:0] a, input logic [15:0] d,
                        input logic hit, input logic [3:0] exp_mode);
    int exp_w;
    exp_w = hit ? int'(POLL_BASE + display_port_pkg::WAIT_PER_TAP * TAP_USED) : 40;
    t_iso = 0;
    t_desel = 0;
    t_conn = 0;
    seen_rd = 1'b0;
    seen_wr = 1'b0;
    rd <= r;
    i_cpu_master.cycle(a, d, w);
    repeat (2) @(posedge clock);
    check("acknowledge polls", 16'(w), 16'(exp_w));
    check("switch order", 16'({t_iso > 0, t_desel > t_iso, t_conn > t_desel}),
          hit ? 16'h0007 : 16'h0000);
    check("direction", 16'({seen_rd, seen_wr}), hit ? 16'({r, !r}) : 16'h0000);
    check("released", 16'({ack_n, sw}), 16'h0017);
    check("mode", 16'(mode), 16'(exp_mode));
  endtask
  // Reset in mid-run: idle pins and a cleared latch, in reset and after it.
  task automatic reset_midrun();
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    check("in reset", 16'({ack_n, sw, display_port_pkg::MODE_RESET}), 16'({1'b1, 4'h7, mode}));
    rst <= 1'b0;
    repeat (2) @(posedge clock);
    check("after reset", 16'({ack_n, sw, mode}), 16'({1'b1, 4'h7, display_port_pkg::MODE_RESET}));
  endtask
  // Clock, cycle ceiling, then reset and the access scenarios.
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) if (++cyc == 1000) end_of_test(1);
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    access(1'b0, 23'h00_6002, 16'h5abc, 1'b1, 4'h5); // Even write loads.
    access(1'b0, 23'h00_6003, 16'ha000, 1'b1, 4'h5); // Odd write holds.
    access(1'b1, 23'h00_6004, 16'hf000, 1'b1, 4'h5); // Read holds.
    access(1'b0, 23'h00_7800, 16'h3000, 1'b0, 4'h5); // Above the window.
    access(1'b0, 23'h00_5fff, 16'h3000, 1'b0, 4'h5); // Below the window.
    access(1'b0, 23'h00_77fe, 16'hc123, 1'b1, 4'hc); // Last even word.
    reset_midrun();
    access(1'b0, 23'h00_6000, 16'h9000, 1'b1, 4'h9); // First word.
    end_of_test(0);
  end
endmodule
`default_nettype wire
